// ---- verilog/chop_drive_pkg.sv ----
// Constants and types shared by the chop drive block
package chop_drive_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_CHOP    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  // MODE register fields
  localparam int MODE_LOWER_BIT      = 0;
  localparam int MODE_UPPER_BIT      = 1;
  localparam int MODE_DIGSEL_BIT     = 2;
  localparam int MODE_ALT_BIT        = 3;
  localparam int MODE_CHOP_BIT       = 4;
  localparam logic [4:0] MODE_RESET  = 5'h00;
  // Default chop half period in core cycles
  localparam logic [15:0] HALF_PERIOD_RESET = 16'h0100;
  // Dead interval: one master clock cycle
  localparam int DEAD_NS             = 50;
  localparam int CLK_PERIOD_NS       = 50;
  localparam int DEAD_CYCLES_I       = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DEAD_CYCLES = DEAD_CYCLES_I[3:0];
  typedef enum logic [1:0] {PH_NORMAL, PH_DEAD_TO_REV, PH_REVERSED, PH_DEAD_TO_NORM} phase_t;
endpackage

// ---- verilog/chop_ctrl_if.sv ----
// Interface between register file and phase sequencer
`timescale 1ns/1ps
interface chop_ctrl_if;
  logic        run;
  logic [15:0] half_period;
  logic        phase;
  logic        phase_n;
  logic [1:0]  state;
  modport ctrl (output run, output half_period, input phase, input phase_n, input state);
  modport seq  (input run, input half_period, output phase, output phase_n, output state);
endinterface

// ---- verilog/chop_phase_seq.sv ----
// Non-overlapping excitation phase sequencer
`timescale 1ns/1ps
module chop_phase_seq (
  input  wire logic  i_core_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_clk_en,
  chop_ctrl_if.seq   ctl
);
  chop_drive_pkg::phase_t state_ff;
  chop_drive_pkg::phase_t nxt_state;
  logic [15:0]            cnt_ff;
  logic [15:0]            nxt_cnt;
  logic                   phase_ff;
  logic                   nxt_phase;
  logic                   phase_n_ff;
  logic                   nxt_phase_n;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff + 16'h0001;
    nxt_phase   = phase_ff;
    nxt_phase_n = phase_n_ff;
    if (!ctl.run) begin
      nxt_state   = chop_drive_pkg::PH_NORMAL;
      nxt_cnt     = 16'h0000;
      nxt_phase   = 1'b1;
      nxt_phase_n = 1'b0;
    end else begin
      unique case (state_ff)
        chop_drive_pkg::PH_NORMAL: begin
          if (cnt_ff + 16'h0001 >= ctl.half_period) begin
            nxt_state = chop_drive_pkg::PH_DEAD_TO_REV;
            nxt_cnt   = 16'h0000;
            nxt_phase = 1'b0;
          end
        end
        chop_drive_pkg::PH_DEAD_TO_REV: begin
          if (cnt_ff[3:0] + 4'h1 >= chop_drive_pkg::DEAD_CYCLES) begin
            nxt_state   = chop_drive_pkg::PH_REVERSED;
            nxt_cnt     = 16'h0000;
            nxt_phase_n = 1'b1;
          end
        end
        chop_drive_pkg::PH_REVERSED: begin
          if (cnt_ff + 16'h0001 >= ctl.half_period) begin
            nxt_state   = chop_drive_pkg::PH_DEAD_TO_NORM;
            nxt_cnt     = 16'h0000;
            nxt_phase_n = 1'b0;
          end
        end
        chop_drive_pkg::PH_DEAD_TO_NORM: begin
          if (cnt_ff[3:0] + 4'h1 >= chop_drive_pkg::DEAD_CYCLES) begin
            nxt_state = chop_drive_pkg::PH_NORMAL;
            nxt_cnt   = 16'h0000;
            nxt_phase = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff   <= chop_drive_pkg::PH_NORMAL;
      cnt_ff     <= 16'h0000;
      phase_ff   <= 1'b1;
      phase_n_ff <= 1'b0;
    end else if (i_clk_en) begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      phase_ff   <= nxt_phase;
      phase_n_ff <= nxt_phase_n;
    end
  end

  assign ctl.phase   = phase_ff;
  assign ctl.phase_n = phase_n_ff;
  assign ctl.state   = state_ff;

  ////////////////////////////////////////////////////////////////////
  no_overlap_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !(phase_ff && phase_n_ff)) else $error("Phase outputs overlap high");
  dead_gap_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(phase_ff) && i_clk_en && ctl.run) |-> !phase_n_ff) else $error("No dead cycle");
endmodule

// ---- verilog/chop_drive.sv ----
// Excitation chop drive and shared digital output pins with APB registers
`timescale 1ns/1ps
// Behaviour
// - Select bit chooses analog or digital pins
// - Positive pin follows upper output bit
// - Negative pin follows lower output bit
// - Phase high normal, low reversed
// - Phase held high unless both modes set
// - Inverted phase is complement of phase except in dead cycles
// - Inverted phase held low when idle
// - One cycle both low at toggles; none when chopping stops in the reversed phase
// - Reset returns all bits to power-on
module chop_drive (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_excitation_phase,
  output logic             o_excitation_phase_n,
  output logic             o_secondary_positive_pin,
  output logic             o_secondary_negative_pin,
  output logic             o_secondary_positive_pin_oe_n,
  output logic             o_secondary_negative_pin_oe_n
);
  logic [4:0]  mode_ff;
  logic [4:0]  nxt_mode;
  logic [15:0] half_ff;
  logic [15:0] nxt_half;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic [3:0]  pins_ff;
  logic [3:0]  nxt_pins;
  logic [1:0]  exc_ff;
  logic [1:0]  nxt_exc;
  logic        setup;
  logic        access_ok;
  logic        mapped;
  logic        upper_output_bit;
  logic        lower_output_bit;
  logic        digital_pin_select;
  chop_ctrl_if ctl ();

  assign upper_output_bit   = mode_ff[chop_drive_pkg::MODE_UPPER_BIT];
  assign lower_output_bit   = mode_ff[chop_drive_pkg::MODE_LOWER_BIT];
  assign digital_pin_select = mode_ff[chop_drive_pkg::MODE_DIGSEL_BIT];
  // Both mode bits must be set before the sequencer may toggle
  assign ctl.run = mode_ff[chop_drive_pkg::MODE_ALT_BIT]
                 & mode_ff[chop_drive_pkg::MODE_CHOP_BIT];
  // Zero half period is clamped to one; both give one-cycle phases
  assign ctl.half_period = (half_ff == 16'h0000) ? 16'h0001 : half_ff;

  chop_phase_seq u_seq (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_clk_en   (i_clk_en),
    .ctl        (ctl)
  );

  ////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, answer registered
  assign setup  = i_psel & ~i_penable;
  // Writes land only at the edge where the master samples pready high
  assign access_ok = i_psel & i_penable & pready_ff;
  assign mapped = (i_paddr == chop_drive_pkg::OFS_MODE)
               || (i_paddr == chop_drive_pkg::OFS_CHOP)
               || (i_paddr == chop_drive_pkg::OFS_STATUS);

  always_comb begin
    nxt_mode    = mode_ff;
    nxt_half    = half_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    if (access_ok && i_pwrite) begin
      if (i_paddr == chop_drive_pkg::OFS_MODE && i_pstrb[0]) begin
        nxt_mode = i_pwdata[4:0];
      end
      if (i_paddr == chop_drive_pkg::OFS_CHOP) begin
        if (i_pstrb[0]) begin
          nxt_half[7:0] = i_pwdata[7:0];
        end
        if (i_pstrb[1]) begin
          nxt_half[15:8] = i_pwdata[15:8];
        end
      end
    end
    if (setup) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = ~mapped;
      nxt_prdata  = 32'h0000_0000;
      if (!i_pwrite) begin
        unique case (i_paddr)
          chop_drive_pkg::OFS_MODE:   nxt_prdata = {27'h0000000, mode_ff};
          chop_drive_pkg::OFS_CHOP:   nxt_prdata = {16'h0000, half_ff};
          chop_drive_pkg::OFS_STATUS: nxt_prdata = {28'h0000000, ctl.state,
                                                    ctl.phase_n, ctl.phase};
          default:                    nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ff    <= chop_drive_pkg::MODE_RESET;
      half_ff    <= chop_drive_pkg::HALF_PERIOD_RESET;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (i_clk_en) begin
      mode_ff    <= nxt_mode;
      half_ff    <= nxt_half;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered
  always_comb begin
    nxt_exc  = {ctl.phase_n, ctl.phase};
    nxt_pins[0] = digital_pin_select & upper_output_bit;
    nxt_pins[1] = digital_pin_select & lower_output_bit;
    // Enables low while driving; released in analog mode
    nxt_pins[2] = ~digital_pin_select;
    nxt_pins[3] = ~digital_pin_select;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exc_ff  <= 2'h1;
      pins_ff <= 4'hC;
    end else if (i_clk_en) begin
      exc_ff  <= nxt_exc;
      pins_ff <= nxt_pins;
    end
  end

  assign o_excitation_phase            = exc_ff[0];
  assign o_excitation_phase_n          = exc_ff[1];
  assign o_secondary_positive_pin      = pins_ff[0];
  assign o_secondary_negative_pin      = pins_ff[1];
  assign o_secondary_positive_pin_oe_n = pins_ff[2];
  assign o_secondary_negative_pin_oe_n = pins_ff[3];
  assign o_prdata                      = prdata_ff;
  assign o_pready                      = pready_ff;
  assign o_pslverr                     = pslverr_ff;

  ////////////////////////////////////////////////////////////////////
  idle_high_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!ctl.run && i_clk_en) ##1 (!ctl.run && i_clk_en) |=> o_excitation_phase)
    else $error("Phase not high when idle");
  idle_low_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!ctl.run && i_clk_en) ##1 (!ctl.run && i_clk_en) |=> !o_excitation_phase_n)
    else $error("Inverted phase not low when idle");
  pins_never_both_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !(o_excitation_phase && o_excitation_phase_n)) else $error("Pins overlap");
  upper_pin_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && digital_pin_select) |=> o_secondary_positive_pin == $past(upper_output_bit))
    else $error("Positive pin wrong");
  lower_pin_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && digital_pin_select) |=> o_secondary_negative_pin == $past(lower_output_bit))
    else $error("Negative pin wrong");
  pin_select_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_clk_en |=> o_secondary_positive_pin_oe_n == !$past(digital_pin_select))
    else $error("Pin enable wrong");
  apb_answer_a : assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (setup && i_clk_en) |=> o_pready) else $error("APB not answered");
endmodule

// ---- dv/bridge_switch_model.sv ----
// Model of the external switch that reverses the bridge excitation
`timescale 1ns/1ps
module bridge_switch_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_excitation_phase,
  input  wire logic        i_excitation_phase_n,
  output logic             o_overlap_seen,
  output logic      [15:0] o_reversals
);
  logic prev_n_ff = 1'b0;
  initial o_overlap_seen = 1'b0;
  initial o_reversals = 16'h0000;
  // Not cleared by reset: a short during reset must stay visible
  always @(posedge i_core_clk) begin
    if (i_excitation_phase === 1'b1 && i_excitation_phase_n === 1'b1) begin
      o_overlap_seen <= 1'b1;
    end
    if (i_excitation_phase_n === 1'b1 && prev_n_ff === 1'b0) begin
      o_reversals <= o_reversals + 16'h0001;
    end
    prev_n_ff <= i_excitation_phase_n;
  end
endmodule

// ---- dv/bridge_chop_drive_outputs_tb_top.sv ----
// Self-checking bench for the chop drive and shared output pins
`timescale 1ns/1ps
module bridge_chop_drive_outputs_tb_top;
  typedef struct {logic [4:0] mode; logic [5:0] exp;} row_t;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ph, phn, pp, pn, ppoe, pnoe, ovl, err, clk_en;
  logic [15:0] revs;
  logic        ph_s [40];
  logic        pn_s [40];
  int          num_errors, n_checks, falls;
  // Rows: mode value, then {phase, phase_n, pos, neg, pos_oe_n, neg_oe_n}
  row_t rows [6] = '{'{5'h03, 6'h23}, '{5'h07, 6'h2C}, '{5'h06, 6'h28},
                     '{5'h05, 6'h24}, '{5'h0F, 6'h2C}, '{5'h14, 6'h20}};
  chop_drive uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_excitation_phase(ph), .o_excitation_phase_n(phn), .o_secondary_positive_pin(pp),
    .o_secondary_negative_pin(pn), .o_secondary_positive_pin_oe_n(ppoe),
    .o_secondary_negative_pin_oe_n(pnoe));
  bridge_switch_model far_end (.i_core_clk(clk), .i_excitation_phase(ph),
    .i_excitation_phase_n(phn), .o_overlap_seen(ovl), .o_reversals(revs));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Answer is taken at the rising edge where pready is sampled high
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input string name, input logic [5:0] exp);
    chk(name, {26'h0, ph, phn, pp, pn, ppoe, pnoe}, {26'h0, exp});
  endtask
  initial begin
    #1000000;
    num_errors++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; clk_en = 1'b1;
    paddr = 8'h00; pwdata = 32'h0000_0000; num_errors = 0; n_checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    pins("reset_pins", 6'h23);
    foreach (rows[i]) begin
      apb(1'b1, chop_drive_pkg::OFS_MODE, {27'h0, rows[i].mode});
      repeat (2) @(negedge clk);
      pins("mode_pins", rows[i].exp);
      apb(1'b0, chop_drive_pkg::OFS_MODE, 32'h0);
      chk("mode_read", rd, {27'h0, rows[i].mode});
    end
    // Short half period keeps the toggle check brief
    apb(1'b1, chop_drive_pkg::OFS_CHOP, 32'h0000_0002);
    apb(1'b1, chop_drive_pkg::OFS_MODE, 32'h0000_0018);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      ph_s[i] = ph;
      pn_s[i] = phn;
    end
    falls = 0;
    for (int i = 1; i < 38; i++) begin
      chk("no_overlap", {31'h0, ph_s[i] & pn_s[i]}, 32'h0);
      if (ph_s[i-1] === 1'b1 && ph_s[i] === 1'b0) begin
        falls++;
        chk("dead_gap", {30'h0, pn_s[i], pn_s[i+1]}, 32'h1);
      end
      if (pn_s[i-1] === 1'b0 && pn_s[i] === 1'b1) begin
        chk("rev_run", {30'h0, pn_s[i+1], pn_s[i+2]}, 32'h2);
      end
    end
    chk("toggles", {31'h0, falls > 2}, 32'h1);
    // Low clock enable must freeze the running sequencer
    @(posedge clk);
    clk_en <= 1'b0;
    @(negedge clk);
    rd = {30'h0, ph, phn};
    repeat (4) @(negedge clk);
    chk("frozen", {30'h0, ph, phn}, rd);
    @(posedge clk);
    clk_en <= 1'b1;
    apb(1'b1, chop_drive_pkg::OFS_MODE, 32'h0000_0008);
    repeat (3) @(negedge clk);
    pins("chop_off", 6'h23);
    apb(1'b1, chop_drive_pkg::OFS_MODE, 32'h0000_001F);
    repeat (9) @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    pins("mid_reset", 6'h23);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, chop_drive_pkg::OFS_MODE, 32'h0);
    chk("mode_after_reset", rd, 32'h0);
    apb(1'b0, chop_drive_pkg::OFS_CHOP, 32'h0);
    chk("chop_after_reset", rd, 32'h0000_0100);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    chk("switch_short", {31'h0, ovl}, 32'h0);
    chk("switch_reversed", {31'h0, revs != 16'h0000}, 32'h1);
    final_report();
  end
endmodule
